// ===== design/pdc_stage.sv
// Output stage of one PWM operator: software force, dead-time switches and carrier chopping.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module pdc_stage (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Generator side, same clock.
	input  wire logic        gen_a,
	input  wire logic        gen_b,
	input  wire logic        timing_event,
	input  wire logic        timer_tick,
	input  wire logic        shadow_update,
	// Gate driver side.
	output logic             out_a,
	output logic             out_b
);

	logic [6:0]               force_cfg_reg;
	pdc_pkg::pdc_switch_t     sw_reg;
	logic                     delay_clock_sel_reg;
	logic [pdc_pkg::DLY_W-1:0] rise_shadow_reg;
	logic [pdc_pkg::DLY_W-1:0] fall_shadow_reg;
	logic [pdc_pkg::DLY_W-1:0] rise_active_reg;
	logic [pdc_pkg::DLY_W-1:0] fall_active_reg;
	pdc_pkg::pdc_chop_t       chop_reg;
	logic [1:0]               held_on_reg;
	logic [1:0]               held_pend_reg;
	logic [1:0]               once_on_reg;
	logic [1:0]               forced_reg;
	logic [1:0]               dly_q_reg;
	logic [pdc_pkg::DLY_W-1:0] dly_cnt_reg [2];
	logic [1:0]               prev_sig_reg;
	logic [3:0]               pre_cnt_reg [2];
	logic [2:0]               phase_reg [2];
	logic [11:0]              first_cnt_reg [2];

	logic                     wr_en;
	logic                     rd_setup;
	logic                     addr_ok;
	logic [31:0]              rd_data;
	logic [1:0]               gen_in;
	logic [1:0]               held_en_w;
	logic [1:0]               held_lvl;
	logic [1:0]               once_lvl;
	logic [1:0]               once_go;
	logic                     dt_tick;
	logic [1:0]               dly_in;
	logic [1:0]               dly_out;
	logic                     mix_a;
	logic                     mix_b;
	logic [1:0]               sig;
	logic [1:0]               chop_out;
	logic [11:0]              first_len;

	// Length of the first carrier pulse in PWM clocks.
	function automatic logic [11:0] first_pulse_len(input logic [3:0] width, input logic [3:0] div);
		logic [11:0] prod;
		prod = ({8'h00, width} + 12'h001) * ({8'h00, div} + 12'h001);
		return prod << pdc_pkg::FIRST_UNIT_LOG;
	endfunction

	// Register bus: zero wait states, read data prepared during the setup phase.
	assign wr_en    = psel && penable && pwrite;
	assign rd_setup = psel && !penable;
	assign addr_ok  = (paddr == pdc_pkg::OFS_FORCE) || (paddr == pdc_pkg::OFS_DT_CFG) ||
	                  (paddr == pdc_pkg::OFS_RISE) || (paddr == pdc_pkg::OFS_FALL) ||
	                  (paddr == pdc_pkg::OFS_CHOP) || (paddr == pdc_pkg::OFS_STATUS) ||
	                  (paddr == pdc_pkg::OFS_ACTIVE);

	always_comb begin
		rd_data = 32'h0000_0000;
		case (paddr)
			pdc_pkg::OFS_FORCE:  rd_data = {25'h0, force_cfg_reg};
			pdc_pkg::OFS_DT_CFG: rd_data = {22'h0, delay_clock_sel_reg, sw_reg};
			pdc_pkg::OFS_RISE:   rd_data = {16'h0, rise_shadow_reg};
			pdc_pkg::OFS_FALL:   rd_data = {16'h0, fall_shadow_reg};
			pdc_pkg::OFS_CHOP:   rd_data = {20'h0, chop_reg};
			pdc_pkg::OFS_STATUS: rd_data = {24'h0, held_pend_reg, once_on_reg, held_on_reg, out_b, out_a};
			pdc_pkg::OFS_ACTIVE: rd_data = {fall_active_reg, rise_active_reg};
			default:             rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready  <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (rd_setup) begin
				prdata  <= pwrite ? 32'h0000_0000 : rd_data;
				pslverr <= !addr_ok;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_cfg_reg   <= pdc_pkg::RST_FORCE;
			sw_reg          <= pdc_pkg::RST_DT_CFG[8:0];
			delay_clock_sel_reg  <= pdc_pkg::RST_DT_CFG[pdc_pkg::DELAY_CLOCK_SEL_BIT];
			rise_shadow_reg <= pdc_pkg::RST_DELAY;
			fall_shadow_reg <= pdc_pkg::RST_DELAY;
			chop_reg        <= pdc_pkg::RST_CHOP;
		end else if (wr_en && pready) begin
			case (paddr)
				pdc_pkg::OFS_FORCE:  force_cfg_reg <= pwdata[6:0];
				pdc_pkg::OFS_DT_CFG: begin
					sw_reg         <= pwdata[8:0];
					delay_clock_sel_reg <= pwdata[pdc_pkg::DELAY_CLOCK_SEL_BIT];
				end
				pdc_pkg::OFS_RISE:   rise_shadow_reg <= pwdata[15:0];
				pdc_pkg::OFS_FALL:   fall_shadow_reg <= pwdata[15:0];
				pdc_pkg::OFS_CHOP:   chop_reg <= pwdata[11:0];
				default:             ;
			endcase
		end
	end

	// Active delays move only at the operator's shadow update.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise_active_reg <= pdc_pkg::RST_DELAY;
			fall_active_reg <= pdc_pkg::RST_DELAY;
		end else if (shadow_update) begin
			rise_active_reg <= rise_shadow_reg;
			fall_active_reg <= fall_shadow_reg;
		end
	end

	// Software force, channel 0 is A and channel 1 is B.
	assign gen_in    = {gen_b, gen_a};
	assign held_en_w = {pwdata[pdc_pkg::FRC_B_HELD_EN], pwdata[pdc_pkg::FRC_A_HELD_EN]};
	assign held_lvl  = {force_cfg_reg[pdc_pkg::FRC_B_HELD_LVL], force_cfg_reg[pdc_pkg::FRC_A_HELD_LVL]};
	assign once_lvl  = {force_cfg_reg[pdc_pkg::FRC_B_ONCE_LVL], force_cfg_reg[pdc_pkg::FRC_A_ONCE_LVL]};
	assign once_go   = (wr_en && pready && paddr == pdc_pkg::OFS_FORCE) ?
	                   {pwdata[pdc_pkg::FRC_B_ONCE_GO], pwdata[pdc_pkg::FRC_A_ONCE_GO]} : 2'b00;

	for (genvar c = 0; c < 2; c++) begin : g_force
		logic frc_wr;
		assign frc_wr = wr_en && pready && (paddr == pdc_pkg::OFS_FORCE);

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				held_on_reg[c]   <= 1'b0;
				held_pend_reg[c] <= 1'b0;
			end else if (frc_wr) begin
				// Release is always immediate; the trigger choice applies to starting only.
				held_on_reg[c]   <= held_en_w[c] && !pwdata[pdc_pkg::FRC_ON_EVENT];
				held_pend_reg[c] <= held_en_w[c] && pwdata[pdc_pkg::FRC_ON_EVENT];
			end else if (held_pend_reg[c] && timing_event) begin
				held_on_reg[c]   <= 1'b1;
				held_pend_reg[c] <= 1'b0;
			end
		end

		// A fresh force fired in the same cycle as a timing event survives it.
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				once_on_reg[c] <= 1'b0;
			end else if (once_go[c]) begin
				once_on_reg[c] <= 1'b1;
			end else if (timing_event) begin
				once_on_reg[c] <= 1'b0;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				forced_reg[c] <= 1'b0;
			end else if (held_on_reg[c]) begin
				forced_reg[c] <= held_lvl[c];
			end else if (once_go[c]) begin
				forced_reg[c] <= pwdata[pdc_pkg::FRC_A_ONCE_LVL + c];
			end else if (once_on_reg[c] && !timing_event) begin
				forced_reg[c] <= once_lvl[c];
			end else begin
				forced_reg[c] <= gen_in[c];
			end
		end
	end

	// Delay paths: index 0 delays rising edges, index 1 delays falling edges.
	assign dt_tick   = delay_clock_sel_reg ? timer_tick : 1'b1;
	assign dly_in[0] = sw_reg.rise_path_source ? forced_reg[1] : forced_reg[0];
	assign dly_in[1] = sw_reg.dual_edge_b_mode ? dly_q_reg[0] :
	                   (sw_reg.fall_path_source ? forced_reg[1] : forced_reg[0]);

	for (genvar d = 0; d < 2; d++) begin : g_delay
		localparam logic EDGE_LVL = (d == 0) ? 1'b1 : 1'b0;
		logic [pdc_pkg::DLY_W-1:0] limit;
		assign limit = (d == 0) ? rise_active_reg : fall_active_reg;

		// An edge is passed once the input has held the new level for limit delay clocks.
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				dly_q_reg[d]   <= 1'b0;
				dly_cnt_reg[d] <= pdc_pkg::RST_DELAY;
			end else if (dly_in[d] != EDGE_LVL) begin
				dly_q_reg[d]   <= dly_in[d];
				dly_cnt_reg[d] <= pdc_pkg::RST_DELAY;
			end else if (dly_q_reg[d] != EDGE_LVL) begin
				if (dly_cnt_reg[d] >= limit) begin
					dly_q_reg[d] <= EDGE_LVL;
				end else if (dt_tick) begin
					dly_cnt_reg[d] <= dly_cnt_reg[d] + 16'h0001;
				end
			end
		end
	end

	// Inversion, bypass, then swap ahead of the carrier.
	assign dly_out[0] = dly_q_reg[0] ^ sw_reg.rise_path_invert;
	assign dly_out[1] = dly_q_reg[1] ^ sw_reg.fall_path_invert;
	assign mix_a      = sw_reg.a_path_bypass ? forced_reg[0] : dly_out[0];
	assign mix_b      = sw_reg.b_path_bypass ? forced_reg[1] : dly_out[1];
	assign sig[0]     = sw_reg.a_output_swap ? mix_b : mix_a;
	assign sig[1]     = sw_reg.b_output_swap ? mix_a : mix_b;
	assign first_len  = first_pulse_len(chop_reg.first_pulse_width, chop_reg.chop_divider);

	// Carrier: each channel restarts its own train on its own rising edge.
	for (genvar c = 0; c < 2; c++) begin : g_chop
		logic rise_edge;
		logic chop_tick;
		logic first_on;
		assign rise_edge   = sig[c] && !prev_sig_reg[c];
		assign chop_tick   = (pre_cnt_reg[c] == chop_reg.chop_divider);
		assign first_on    = rise_edge || (first_cnt_reg[c] != 12'h000);
		assign chop_out[c] = sig[c] && (first_on || (phase_reg[c] < chop_reg.chop_duty));

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				prev_sig_reg[c]  <= 1'b0;
				pre_cnt_reg[c]   <= 4'h0;
				phase_reg[c]     <= 3'h0;
				first_cnt_reg[c] <= 12'h000;
			end else begin
				prev_sig_reg[c] <= sig[c];
				if (rise_edge) begin
					pre_cnt_reg[c]   <= 4'h0;
					phase_reg[c]     <= 3'h0;
					first_cnt_reg[c] <= first_len - 12'h001;
				end else begin
					pre_cnt_reg[c] <= chop_tick ? 4'h0 : pre_cnt_reg[c] + 4'h1;
					if (chop_tick) begin
						phase_reg[c] <= (phase_reg[c] == pdc_pkg::CHOP_PHASE_MAX) ? 3'h0 : phase_reg[c] + 3'h1;
					end
					if (first_cnt_reg[c] != 12'h000) begin
						first_cnt_reg[c] <= first_cnt_reg[c] - 12'h001;
					end
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_a <= 1'b0;
			out_b <= 1'b0;
		end else begin
			out_a <= chop_reg.chop_enable ? chop_out[0] : sig[0];
			out_b <= chop_reg.chop_enable ? chop_out[1] : sig[1];
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_once_force_now: assert property (once_go[0] && !held_on_reg[0] |=> forced_reg[0] == $past(pwdata[5]))
		else $error("one-time force on A did not apply at once");
	a_once_force_ends: assert property (once_on_reg[0] && timing_event && !once_go[0] && !held_on_reg[0]
		|=> !once_on_reg[0] && forced_reg[0] == $past(gen_a))
		else $error("one-time force on A outlived the timing event");
	a_held_force_level: assert property (held_on_reg[1] && $past(held_on_reg[1]) |-> forced_reg[1] == $past(held_lvl[1]))
		else $error("held force on B let the generator through");
	a_held_event_start: assert property (held_pend_reg[0] && timing_event && !wr_en |=> held_on_reg[0] ##1 forced_reg[0] == $past(held_lvl[0]))
		else $error("held force on A did not start on the timing event");
	a_bypass_pass: assert property (sw_reg.a_path_bypass && sw_reg.b_path_bypass && !sw_reg.a_output_swap &&
		!sw_reg.b_output_swap && !chop_reg.chop_enable |=> out_a == $past(forced_reg[0]) && out_b == $past(forced_reg[1]))
		else $error("pass-through mode altered an output");
	a_rise_delay_count: assert property (!dly_q_reg[0] ##1 dly_q_reg[0] |-> $past(dly_cnt_reg[0]) >= $past(rise_active_reg))
		else $error("rising edge passed before its delay");
	a_fall_delay_count: assert property (dly_q_reg[1] ##1 !dly_q_reg[1] |-> $past(dly_cnt_reg[1]) >= $past(fall_active_reg))
		else $error("falling edge passed before its delay");
	a_shadow_load: assert property (shadow_update |=> rise_active_reg == $past(rise_shadow_reg) && fall_active_reg == $past(fall_shadow_reg))
		else $error("active delay did not load from shadow");
	a_chop_off_pass: assert property (!chop_reg.chop_enable |=> out_a == $past(sig[0]) && out_b == $past(sig[1]))
		else $error("disabled carrier altered the signal");
	a_chop_and_gate: assert property (out_a |-> $past(sig[0]))
		else $error("carrier output high while signal low");
	a_first_pulse_len: assert property (g_chop[0].rise_edge |=> first_cnt_reg[0] == $past(first_len) - 12'h001)
		else $error("first pulse length loaded wrongly");

	c_first_pulse: cover property (chop_reg.chop_enable && g_chop[0].rise_edge ##1 first_cnt_reg[0] != 12'h000);
	c_held_event: cover property (held_pend_reg[1] ##[1:20] held_on_reg[1]);
	c_once_force: cover property (once_go[0] ##[1:20] timing_event);
	c_rise_delay: cover property (!dly_q_reg[0] && rise_active_reg > 16'h0002 ##1 dly_q_reg[0]);

endmodule // pdc_stage

// ===== design/pdc_pkg.sv
// Package with register map, field layouts and carrier types for the PWM dead-time and carrier output stage.
// Contract
// - A one-time force changes the selected output immediately when software fires it.
// - After a one-time force, the next timing event lets the generator drive again.
// - A held force keeps its level, ignoring the generator, until software releases it.
// - A held force starts either on a timing event or at once, by configuration.
// - Both outputs can be made from input A alone, with rise and fall delays.
// - Nine independent switches S0 to S8; every combination of them works.
// - S0/S1 bypass B/A, S2/S3 invert, S4/S5 pick sources, S6/S7 swap, S8 mode.
// - Both bypasses set: both inputs pass unchanged and undelayed, inversion ignored.
// - Bypasses clear: invert pairs 01, 10, 00, 11 give the four polarity modes.
// - Only A bypassed: A passes undelayed, B is A with fall delay.
// - Only B bypassed: A is A with rise delay, B passes undelayed.
// - Typical modes use input A for both delay paths, S4 to S8 zero.
// - Rise and fall delays are programmed independently.
// - Each delay is sixteen bits, counted in delay clock periods.
// - The delay clock is the PWM clock or the timer clock, by configuration.
// - Delay values are shadowed and take effect only at the shadow update.
// - Carrier clock is the PWM clock divided by a prescale; a duty field sets duty.
// - First carrier pulse lasts 8 times (prescale+1) times (width+1) PWM clocks.
// - After the first pulse, narrower sustaining pulses follow for the rest of the pulse.
// - One enable bit turns the carrier on; when off the signal passes unmodulated.
// - Sustaining duty is the three-bit field at bits 7 to 5, divided by eight.
package pdc_pkg;

	localparam logic [7:0]  OFS_FORCE    = 8'h00;
	localparam logic [7:0]  OFS_DT_CFG   = 8'h04;
	localparam logic [7:0]  OFS_RISE     = 8'h08;
	localparam logic [7:0]  OFS_FALL     = 8'h0C;
	localparam logic [7:0]  OFS_CHOP     = 8'h10;
	localparam logic [7:0]  OFS_STATUS   = 8'h14;
	localparam logic [7:0]  OFS_ACTIVE   = 8'h18;

	// Force register fields.
	localparam int          FRC_A_HELD_EN  = 0;
	localparam int          FRC_A_HELD_LVL = 1;
	localparam int          FRC_B_HELD_EN  = 2;
	localparam int          FRC_B_HELD_LVL = 3;
	localparam int          FRC_ON_EVENT   = 4;
	localparam int          FRC_A_ONCE_LVL = 5;
	localparam int          FRC_B_ONCE_LVL = 6;
	localparam int          FRC_A_ONCE_GO  = 8;
	localparam int          FRC_B_ONCE_GO  = 9;
	localparam logic [6:0]  RST_FORCE      = 7'h00;

	localparam int          DLY_W          = 16;
	localparam logic [15:0] RST_DELAY      = 16'h0000;
	localparam logic [9:0]  RST_DT_CFG     = 10'h000;
	localparam int          DELAY_CLOCK_SEL_BIT = 9;
	localparam logic [11:0] RST_CHOP       = 12'h000;
	localparam logic [2:0]  CHOP_PHASE_MAX = 3'h7;
	localparam int          FIRST_UNIT_LOG = 3;

	// Bit i of this struct is switch Si.
	typedef struct packed {
		logic dual_edge_b_mode;
		logic b_output_swap;
		logic a_output_swap;
		logic fall_path_source;
		logic rise_path_source;
		logic fall_path_invert;
		logic rise_path_invert;
		logic a_path_bypass;
		logic b_path_bypass;
	} pdc_switch_t;

	// Carrier configuration word, bits 11:8, 7:5, 4:1 and 0.
	typedef struct packed {
		logic [3:0] first_pulse_width;
		logic [2:0] chop_duty;
		logic [3:0] chop_divider;
		logic       chop_enable;
	} pdc_chop_t;

endpackage

// ===== dv/pdc_gate_drv.sv
// Gate driver model that records the widths of the high runs it sees on the A gate input.
`timescale 1ns/1ps
module pdc_gate_drv (
	// Clock and control.
	input  wire logic pclk,
	input  wire logic clr,
	// Gate input from the stage.
	input  wire logic out_a
);
	int w_a [0:7];
	int n_a;
	int run;

	// A transformer-coupled driver sees only the pulse widths, so these are all we keep.
	always @(posedge pclk) begin
		if (clr) begin
			n_a = 0;
			run = 0;
		end else if (out_a === 1'b1) begin
			run++;
		end else if (run > 0) begin
			if (n_a < 8) w_a[n_a] = run;
			n_a++;
			run = 0;
		end
	end
endmodule // pdc_gate_drv

// ===== dv/pdc_stage_bench.sv
// Self-checking bench for the PWM dead-time and carrier output stage.
`timescale 1ns/1ps
module pdc_stage_bench;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, er;
	logic        gen_a, gen_b, timing_event, timer_tick, shadow_update;
	logic        out_a, out_b, drv_clr;
	int          errors, samples_checked;
	int          c_r0, c_f0, c_r, c_f;

	pdc_stage u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.gen_a(gen_a), .gen_b(gen_b), .timing_event(timing_event), .timer_tick(timer_tick),
		.shadow_update(shadow_update), .out_a(out_a), .out_b(out_b));
	pdc_gate_drv u_drv (.pclk(pclk), .clr(drv_clr), .out_a(out_a));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// One APB transfer; an extra edge after release keeps back-to-back calls from driving psel twice.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 64) begin
			errors++;
			finish_test();
		end
		@(posedge pclk);
	endtask

	task automatic pulse(input logic sh);
		if (sh) shadow_update <= 1'b1;
		else timing_event <= 1'b1;
		@(posedge pclk);
		shadow_update <= 1'b0;
		timing_event <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic t_regs();
		apb(1'b0, pdc_pkg::OFS_DT_CFG, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, pdc_pkg::OFS_CHOP, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 8'h1C, 32'hFFFF);
		chk(32'(er), 32'h1);
		apb(1'b1, pdc_pkg::OFS_ACTIVE, 32'hFFFFFFFF);
		apb(1'b0, pdc_pkg::OFS_ACTIVE, 32'h0);
		chk(rd, 32'h0);
	endtask

	// Entry: switch word, gen_a, gen_b, expected out_a, expected out_b.
	task automatic t_modes();
		logic [13:0] tb [0:11];
		tb = '{14'h049, 14'h046, 14'h08A, 14'h00B, 14'h0C8, 14'h0FA, 14'h0F5, 14'hCF9,
			14'h02B, 14'h01A, 14'h109, 14'h100B};
		foreach (tb[i]) begin
			apb(1'b1, pdc_pkg::OFS_DT_CFG, {22'h0, tb[i][13:4]});
			gen_a <= tb[i][3];
			gen_b <= tb[i][2];
			idle(6);
			chk({30'h0, out_a, out_b}, {30'h0, tb[i][1:0]});
		end
	endtask

	task automatic lat(input logic lvl, output int n);
		gen_a <= lvl;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while ((lvl ? out_a : out_b) !== 1'b1 && n < 200);
		if (n >= 200) begin
			errors++;
			finish_test();
		end
		idle(4);
	endtask

	// Latency is compared against a zero-delay baseline so the fixed pipeline depth cancels out.
	task automatic t_delay();
		apb(1'b1, pdc_pkg::OFS_DT_CFG, 32'h008);
		gen_a <= 1'b0;
		idle(6);
		lat(1'b1, c_r0);
		lat(1'b0, c_f0);
		apb(1'b1, pdc_pkg::OFS_RISE, 32'h000A);
		apb(1'b1, pdc_pkg::OFS_FALL, 32'h0003);
		apb(1'b0, pdc_pkg::OFS_ACTIVE, 32'h0);
		chk(rd, 32'h0);
		pulse(1'b1);
		apb(1'b0, pdc_pkg::OFS_ACTIVE, 32'h0);
		chk(rd, 32'h0003000A);
		lat(1'b1, c_r);
		lat(1'b0, c_f);
		chk(32'(c_r - c_r0), 32'hA);
		chk(32'(c_f - c_f0), 32'h3);
		// With the timer clock selected and no timer ticks, the rising edge must stay held back.
		apb(1'b1, pdc_pkg::OFS_DT_CFG, 32'h208);
		gen_a <= 1'b1;
		idle(30);
		chk(32'(out_a), 32'h0);
		timer_tick <= 1'b1;
		idle(14);
		chk(32'(out_a), 32'h1);
		gen_a <= 1'b0;
		idle(8);
		timer_tick <= 1'b0;
	endtask

	task automatic t_force();
		apb(1'b1, pdc_pkg::OFS_DT_CFG, 32'h00F);
		gen_a <= 1'b1;
		gen_b <= 1'b0;
		idle(4);
		apb(1'b1, pdc_pkg::OFS_FORCE, 32'h1 << pdc_pkg::FRC_A_ONCE_GO);
		idle(2);
		chk(32'(out_a), 32'h0);
		pulse(1'b0);
		idle(3);
		chk(32'(out_a), 32'h1);
		apb(1'b1, pdc_pkg::OFS_FORCE, 32'h1 << pdc_pkg::FRC_A_HELD_EN);
		idle(3);
		chk(32'(out_a), 32'h0);
		pulse(1'b0);
		idle(3);
		chk(32'(out_a), 32'h0);
		apb(1'b1, pdc_pkg::OFS_FORCE, (32'h1 << pdc_pkg::FRC_A_HELD_EN) | (32'h1 << pdc_pkg::FRC_ON_EVENT));
		idle(4);
		chk(32'(out_a), 32'h1);
		pulse(1'b0);
		idle(3);
		chk(32'(out_a), 32'h0);
		apb(1'b1, pdc_pkg::OFS_FORCE, (32'h1 << pdc_pkg::FRC_B_HELD_EN) | (32'h1 << pdc_pkg::FRC_B_HELD_LVL));
		idle(3);
		chk({30'h0, out_a, out_b}, 32'h3);
		apb(1'b1, pdc_pkg::OFS_FORCE, 32'h0);
		idle(3);
		chk({30'h0, out_a, out_b}, 32'h2);
	endtask

	// Entry: carrier word, run index, expected width. Duty 0 isolates the first pulse.
	task automatic t_chop();
		logic [23:0] tb [0:3];
		tb = '{24'h101010, 24'h203030, 24'h081204, 24'h0C320C};
		gen_a <= 1'b0;
		foreach (tb[i]) begin
			apb(1'b1, pdc_pkg::OFS_CHOP, {20'h0, tb[i][23:12]});
			drv_clr <= 1'b1;
			idle(4);
			drv_clr <= 1'b0;
			gen_a <= 1'b1;
			idle(120);
			gen_a <= 1'b0;
			idle(6);
			chk(32'(u_drv.w_a[tb[i][11:8]]), {24'h0, tb[i][7:0]});
		end
		apb(1'b1, pdc_pkg::OFS_CHOP, 32'h0);
	endtask

	initial begin
		errors = 0;
		samples_checked = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		gen_a = 1'b0;
		gen_b = 1'b0;
		timing_event = 1'b0;
		timer_tick = 1'b0;
		shadow_update = 1'b0;
		drv_clr = 1'b1;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		drv_clr <= 1'b0;
		@(posedge pclk);
		t_regs();
		t_modes();
		t_delay();
		t_force();
		t_chop();
		finish_test();
	end
endmodule // pdc_stage_bench
